/* File: hdl/cilm_cfg.svh */
// latency figures and field constants for the instruction latency model
`ifndef CILM_CFG_SVH
`define CILM_CFG_SVH
`define CILM_NREG        16
`define CILM_LW          5
`define CILM_REG_TWELVE  4'hC
`define CILM_REG_PC      4'hF
`define CILM_ET_HI       31
`define CILM_ET_LO1      15
`define CILM_ET_LO2      27
`define CILM_MUL_FAST    5'h01
`define CILM_MUL_MID     5'h02
`define CILM_MUL_SLOW    5'h03
`define CILM_MUL_HALF    5'h01
`define CILM_MUL_DUAL    5'h02
`define CILM_ACC_WR      5'h02
`define CILM_ACC_RD_LO   5'h02
`define CILM_ACC_RD_HI   5'h03
`define CILM_ACC_RD_TP   5'h02
`define CILM_SAT_RES     5'h02
`define CILM_SR_RD_RES   5'h02
`define CILM_SR_WR_ISS   5'h02
`define CILM_SR_WR_MODE  5'h06
`define CILM_LD_RES      5'h03
`define CILM_LD_RES2     5'h04
`define CILM_ST_DW       5'h02
`define CILM_LM_BASE     5'h02
`define CILM_LM_PREV     5'h03
`define CILM_LM_LAST     5'h04
`define CILM_SWAP        5'h05
`define CILM_SYS_RD      5'h04
`define CILM_SYS_WR      5'h02
`define CILM_DBG         5'h08
`define CILM_DBG_PC      5'h09
`define CILM_CP_LOAD     5'h0B
`define CILM_EXC         5'h06
`define CILM_BR_MISS     5'h05
`define CILM_ONE         5'h01
`endif

/* File: hdl/cilm_core.sv */
// issue sequencer and register scoreboard of the core instruction latency model
`include "cilm_cfg.svh"

module cilm_core
  import cilm_pkg::*;
#(
  parameter int NREG = `CILM_NREG
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // instruction stream
  input  wire logic               instr_valid,
  input  wire cilm_instr_t        instr,
  output logic                    instr_ready,
  input  wire logic               hold,
  // status
  output logic                    handler_start,
  output logic [NREG-1:0]         reg_busy,
  output logic                    mac_busy,
  output logic [`CILM_LW-1:0]     last_issue_lat
);

  localparam int LW = `CILM_LW;

  // issue state
  cilm_state_t      state_reg, state_next;
  logic [LW-1:0]    issue_cnt_reg, issue_cnt_next;
  logic [LW-1:0]    mac_cnt_reg, mac_cnt_next;
  logic             exc_reg, exc_next;
  logic             hstart_reg, hstart_next;
  logic [LW-1:0]    lat_reg, lat_next;
  logic [NREG-1:0]  busy_reg, busy_next;
  // scoreboard
  logic [LW-1:0]    cnt_reg [NREG];
  logic [LW-1:0]    cnt_next [NREG];
  logic [NREG-1:0]  extra_reg, extra_next;
  logic [LW-1:0]    ld_val [NREG];
  logic [NREG-1:0]  ld_en;
  logic [NREG-1:0]  ld_extra;
  // decode
  cilm_lat_t        lat;
  logic [LW-1:0]    numreg;
  int               last_idx;
  int               prev_idx;
  logic             hazard;
  logic             accept;

  // early termination: the top bits must all match bit 31 of the operand
  function automatic logic all_same(input logic [31:0] v, input int lo);
    logic ok;
    ok = 1'b1;
    for (int i = lo; i <= `CILM_ET_HI; i++) begin
      if (v[i] != v[`CILM_ET_HI]) ok = 1'b0;
    end
    return ok;
  endfunction

  // popcount and the two highest listed registers of a multiple transfer
  always_comb begin
    numreg = '0;
    last_idx = -1;
    prev_idx = -1;
    for (int i = 0; i < NREG; i++) begin
      if (instr.reg_list[i]) begin
        numreg = numreg + LW'(1);
        prev_idx = last_idx;
        last_idx = i;
      end
    end
  end

  // latency table lookup
  always_comb begin
    cilm_op_t op;
    op = instr.op;
    lat = '0;
    lat.issue = `CILM_ONE;
    if (op == OP_LINK_HALF && !instr.hi_sel) op = OP_DATA;
    else if (op == OP_LINK_HALF) op = OP_BRANCH;
    // compressed forms share the 32-bit figures below, except a mispredicted branch and a taken pc write, which add one cycle
    case (op)
      OP_DATA, OP_LZ_COUNT: begin
        lat.res1 = `CILM_ONE;
        lat.has_res1 = 1'b1;
      end
      OP_ACC_MUL: begin
        lat.mac = 1'b1;
        if (all_same(instr.mult_operand, `CILM_ET_LO1)) lat.thru = `CILM_MUL_FAST;
        else if (all_same(instr.mult_operand, `CILM_ET_LO2)) lat.thru = `CILM_MUL_MID;
        else lat.thru = `CILM_MUL_SLOW;
      end
      OP_ACC_MUL_HALF: begin
        lat.mac = 1'b1;
        lat.thru = `CILM_MUL_HALF;
      end
      OP_ACC_MUL_DUAL: begin
        lat.mac = 1'b1;
        lat.thru = `CILM_MUL_DUAL;
      end
      OP_ACC_WR: begin
        lat.mac = 1'b1;
        lat.issue = `CILM_ACC_WR;
        lat.thru = `CILM_ACC_WR;
      end
      OP_ACC_RD: begin
        lat.mac = 1'b1;
        lat.thru = `CILM_ACC_RD_TP;
        lat.res1 = `CILM_ACC_RD_LO;
        lat.res2 = `CILM_ACC_RD_HI;
        lat.has_res1 = 1'b1;
        lat.has_res2 = 1'b1;
      end
      OP_SAT: begin
        lat.res1 = `CILM_SAT_RES;
        lat.has_res1 = 1'b1;
      end
      OP_SR_RD: begin
        lat.res1 = `CILM_SR_RD_RES;
        lat.has_res1 = 1'b1;
      end
      OP_SR_WR: begin
        lat.issue = instr.mode_change ? `CILM_SR_WR_MODE : `CILM_SR_WR_ISS;
      end
      OP_LOAD: begin
        lat.res1 = `CILM_LD_RES;
        lat.has_res1 = 1'b1;
        lat.wb = `CILM_ONE;
        lat.has_wb = instr.wb_en;
      end
      OP_LOAD_DW: begin
        lat.issue = `CILM_ONE + LW'(instr.dst == `CILM_REG_TWELVE);
        lat.res1 = `CILM_LD_RES;
        lat.res2 = `CILM_LD_RES2;
        lat.has_res1 = 1'b1;
        lat.has_res2 = 1'b1;
        lat.wb = `CILM_ONE + LW'(instr.dst == `CILM_REG_TWELVE);
        lat.has_wb = instr.wb_en;
      end
      OP_STORE: begin
        lat.wb = `CILM_ONE;
        lat.has_wb = instr.wb_en;
      end
      OP_STORE_DW: begin
        lat.issue = `CILM_ST_DW;
        lat.wb = `CILM_ST_DW;
        lat.has_wb = instr.wb_en;
      end
      OP_LOAD_MULTI, OP_STORE_MULTI: begin
        lat.issue = `CILM_LM_BASE + numreg;
        lat.wb = `CILM_LM_BASE + numreg;
        lat.has_wb = instr.wb_en;
        lat.multi = (op == OP_LOAD_MULTI);
      end
      OP_SWAP: begin
        lat.issue = `CILM_SWAP;
        lat.res1 = `CILM_SWAP;
        lat.has_res1 = 1'b1;
      end
      OP_SYS_RD: begin
        lat.issue = `CILM_SYS_RD;
        lat.res1 = `CILM_SYS_RD;
        lat.has_res1 = 1'b1;
      end
      OP_SYS_WR: lat.issue = `CILM_SYS_WR;
      OP_DBG_RD: begin
        lat.issue = (instr.dst == `CILM_REG_PC) ? `CILM_DBG_PC : `CILM_DBG;
        lat.res1 = lat.issue;
        lat.has_res1 = 1'b1;
      end
      OP_DBG_WR, OP_CP_STORE: lat.issue = `CILM_DBG;
      OP_CP_LOAD: lat.issue = `CILM_CP_LOAD;
      OP_EXCEPT: begin
        lat.issue = `CILM_EXC;
        lat.exc = 1'b1;
      end
      OP_BRANCH: begin
        if (instr.mispredict) lat.issue = `CILM_BR_MISS + LW'(instr.compressed);
      end
      OP_PC_WRITE: begin
        if (instr.taken) lat.issue = instr.pc_issue + LW'(instr.compressed);
      end
      default: lat.issue = `CILM_ONE;                                 // preload hint and the rest
    endcase
  end

  // hazard check: pending sources, the accumulator extra cycle and a busy multiplier
  always_comb begin
    hazard = 1'b0;
    if (instr.src_a_en && cnt_reg[instr.src_a] != '0) hazard = 1'b1;
    if (instr.src_b_en && cnt_reg[instr.src_b] != '0) hazard = 1'b1;
    if (instr.src_a_en && instr.special_use && extra_reg[instr.src_a]) hazard = 1'b1;
    if (lat.mac && mac_cnt_reg != '0) hazard = 1'b1;
  end

  // hold only delays issue; all counters keep running so no latency shrinks
  assign instr_ready = (state_reg == ST_READY) && !hold && !hazard;
  assign accept = instr_valid && instr_ready;

  // scoreboard load values for the accepted instruction
  always_comb begin
    logic [LW-1:0] v;
    v = '0;
    for (int r = 0; r < NREG; r++) begin
      v = '0;
      ld_en[r] = 1'b0;
      ld_extra[r] = 1'b0;
      if (accept) begin
        if (lat.has_res1 && instr.dst == 4'(r)) begin
          v = lat.res1 - LW'(1);
          ld_en[r] = 1'b1;
        end
        if (lat.has_res2 && ((instr.op == OP_ACC_RD) ? instr.dst2 : instr.dst + 4'h1) == 4'(r)) begin
          if (lat.res2 - LW'(1) > v) v = lat.res2 - LW'(1);
          ld_en[r] = 1'b1;
        end
        if (lat.multi && instr.reg_list[r]) begin
          if (r == last_idx) v = `CILM_LM_LAST + numreg - LW'(1);
          else if (r == prev_idx) v = `CILM_LM_PREV + numreg - LW'(1);
          else v = `CILM_LM_BASE + numreg - LW'(1);
          ld_en[r] = 1'b1;
        end
        if (lat.has_wb && instr.base == 4'(r)) begin
          if (lat.wb - LW'(1) > v) v = lat.wb - LW'(1);
          ld_en[r] = 1'b1;
        end
        ld_extra[r] = (instr.op == OP_ACC_RD) && ld_en[r];
      end
      ld_val[r] = v;
    end
  end

  // per-register countdown; a new load never shortens a pending wait
  for (genvar g = 0; g < NREG; g++) begin : g_sb
    logic [LW-1:0] dec;
    always_comb begin
      dec = (cnt_reg[g] != '0) ? cnt_reg[g] - LW'(1) : '0;
      cnt_next[g] = (ld_en[g] && ld_val[g] > dec) ? ld_val[g] : dec;
      // the extra bit outlives the count by one cycle
      extra_next[g] = ld_extra[g] | (extra_reg[g] & (cnt_reg[g] != '0));
      busy_next[g] = (cnt_next[g] != '0);
    end
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        cnt_reg[g] <= '0;
        extra_reg[g] <= 1'b0;
        busy_reg[g] <= 1'b0;
      end else begin
        cnt_reg[g] <= cnt_next[g];
        extra_reg[g] <= extra_next[g];
        busy_reg[g] <= busy_next[g];
      end
    end
  end

  // issue sequencer, multiplier occupancy and exception handler timing
  always_comb begin
    state_next = state_reg;
    issue_cnt_next = (issue_cnt_reg != '0) ? issue_cnt_reg - LW'(1) : '0;
    mac_cnt_next = (mac_cnt_reg != '0) ? mac_cnt_reg - LW'(1) : '0;
    exc_next = exc_reg;
    hstart_next = 1'b0;
    lat_next = lat_reg;
    case (state_reg)
      ST_READY: begin
        if (accept) begin
          lat_next = lat.issue;
          issue_cnt_next = lat.issue - LW'(1);
          exc_next = lat.exc;
          if (lat.mac) mac_cnt_next = lat.thru - LW'(1);
          if (lat.issue > LW'(1)) state_next = ST_ISSUING;
        end
      end
      ST_ISSUING: begin
        // handler start lands exactly when the next issue slot opens
        if (issue_cnt_reg == LW'(1)) begin
          state_next = ST_READY;
          hstart_next = exc_reg;
          exc_next = 1'b0;
        end
      end
      default: state_next = ST_READY;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_READY;
      issue_cnt_reg <= '0;
      mac_cnt_reg <= '0;
      exc_reg <= 1'b0;
      hstart_reg <= 1'b0;
      lat_reg <= '0;
    end else begin
      state_reg <= state_next;
      issue_cnt_reg <= issue_cnt_next;
      mac_cnt_reg <= mac_cnt_next;
      exc_reg <= exc_next;
      hstart_reg <= hstart_next;
      lat_reg <= lat_next;
    end
  end

  // status outputs straight from flops, except mac_busy, which is decoded from the multiplier count
  assign handler_start = hstart_reg;
  assign reg_busy = busy_reg;
  assign mac_busy = (mac_cnt_reg != '0);
  assign last_issue_lat = lat_reg;

endmodule // cilm_core

/* File: hdl/cilm_pkg.sv */
// types for the instruction latency model
package cilm_pkg;
  typedef enum logic [4:0] {
    OP_DATA, OP_ACC_MUL, OP_ACC_MUL_HALF, OP_ACC_MUL_DUAL, OP_ACC_WR, OP_ACC_RD, OP_SAT,
    OP_SR_RD, OP_SR_WR, OP_LOAD, OP_PRELOAD, OP_LOAD_DW, OP_STORE, OP_STORE_DW,
    OP_LOAD_MULTI, OP_STORE_MULTI, OP_SWAP, OP_SYS_RD, OP_SYS_WR, OP_DBG_RD,
    OP_DBG_WR, OP_CP_LOAD, OP_CP_STORE, OP_EXCEPT, OP_LZ_COUNT, OP_BRANCH,
    OP_PC_WRITE, OP_LINK_HALF
  } cilm_op_t;

  typedef struct packed {
    cilm_op_t    op;          // instruction group
    logic        compressed;  // 16-bit encoding
    logic [31:0] mult_operand;// multiplier_operand value for early termination
    logic [3:0]  dst;         // first destination
    logic [3:0]  dst2;        // second destination (accumulator read high word)
    logic [3:0]  base;        // base register
    logic        wb_en;       // base writeback requested
    logic [3:0]  src_a;       // first source
    logic        src_a_en;
    logic [3:0]  src_b;       // second source
    logic        src_b_en;
    logic        special_use; // src_a used as shift-immediate or doubling first_operand
    logic [15:0] reg_list;    // load/store multiple list
    logic        mode_change; // status write changes processor mode bits
    logic        mispredict;  // branch was mispredicted
    logic        taken;       // program-counter write taken
    logic [4:0]  pc_issue;    // 32-bit form issue latency of a taken pc write
    logic        hi_sel;      // high-offset selector of branch_with_link half
  } cilm_instr_t;

  typedef struct packed {
    logic [4:0] issue;
    logic [4:0] res1;
    logic [4:0] res2;
    logic [4:0] wb;
    logic [4:0] thru;
    logic       has_res1;
    logic       has_res2;
    logic       has_wb;
    logic       mac;
    logic       exc;
    logic       multi;
  } cilm_lat_t;

  typedef enum logic {ST_READY, ST_ISSUING} cilm_state_t;
endpackage

/* File: verification/cilm_core_asserts.sv */
// port-level timing checks for the instruction latency core
module cilm_core_asserts
  import cilm_pkg::*;
#(
  parameter int NREG = 16
) (
  // clock and reset
  input wire logic            sys_clk,
  input wire logic            rst,
  // instruction stream
  input wire logic            instr_valid,
  input wire cilm_instr_t     instr,
  input wire logic            instr_ready,
  input wire logic            hold,
  // status
  input wire logic            handler_start,
  input wire logic [NREG-1:0] reg_busy,
  input wire logic            mac_busy,
  input wire logic [4:0]      last_issue_lat
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // an instruction is taken on any edge where both sides agree
  logic acc;
  assign acc = instr_valid && instr_ready;

  hold_blocks_a: assert property (hold |-> !instr_ready)
    else $error("ready raised while held");
  reg_stall_a: assert property (instr_valid && instr.src_a_en && reg_busy[instr.src_a]
    |-> !instr_ready) else $error("reader issued over pending result");
  mac_stall_a: assert property (instr_valid && instr.op == OP_ACC_MUL && mac_busy |-> !instr_ready)
    else $error("multiply issued into busy multiplier");
  exc_entry_a: assert property (acc && instr.op == OP_EXCEPT |=>
    (!instr_ready && !handler_start) [*5] ##1 handler_start) else $error("handler entry not at cycle six");
  load_data_a: assert property (acc && instr.op == OP_LOAD |=>
    reg_busy[$past(instr.dst)] ##1 reg_busy[$past(instr.dst, 2)]) else $error("load data ready too soon");
  swap_issue_a: assert property (acc && instr.op == OP_SWAP |=>
    last_issue_lat == 5'h05 ##0 (!instr_ready) [*4]) else $error("swap issue latency wrong");
  mode_write_a: assert property (acc && instr.op == OP_SR_WR && instr.mode_change |=>
    (!instr_ready) [*5]) else $error("mode write issued too fast");
  ldm_issue_a: assert property (acc && instr.op == OP_LOAD_MULTI |=>
    last_issue_lat == $countones($past(instr.reg_list)) + 2) else $error("load multiple issue latency wrong");
  mul_slow_a: assert property (acc && instr.op == OP_ACC_MUL && (|instr.mult_operand[31:27]) &&
    !(&instr.mult_operand[31:27]) |=> mac_busy [*2]) else $error("slow multiply freed early");
  sat_result_a: assert property (acc && instr.op == OP_SAT |=> reg_busy[$past(instr.dst)])
    else $error("saturating result ready too soon");

  // main scenarios reached
  exc_c: cover property (acc && instr.op == OP_EXCEPT);
  ldm_c: cover property (acc && instr.op == OP_LOAD_MULTI);
  special_c: cover property (instr_valid && instr.special_use && !instr_ready);
  hold_c: cover property (hold && instr_valid);
endmodule // cilm_core_asserts

/* File: verification/cilm_core_test.sv */
// self-checking bench for the instruction latency core
module test_cilm_core;
  import cilm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int NREG = 16;
  localparam cilm_instr_t IDLE = '0;

  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic              instr_valid = 1'b0;
  cilm_instr_t       instr = IDLE;
  logic              hold = 1'b0;
  logic              instr_ready;
  logic              handler_start;
  logic [NREG-1:0]   reg_busy;
  logic              mac_busy;
  logic [4:0]        last_issue_lat;
  int                fail_count = 0;
  int                n_tests = 0;
  int                cyc = 0;

  cilm_core #(.NREG(NREG)) dut (.sys_clk, .rst, .instr_valid, .instr, .instr_ready, .hold,
    .handler_start, .reg_busy, .mac_busy, .last_issue_lat);

  // 40 MHz core clock
  always #12.5 sys_clk = ~sys_clk;

  // hang guard: the whole run needs well under this many cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_n(input int got, exp);
    n_tests++;
    if (got != exp) begin
      fail_count++;
      $display("unexpected at %0t: count %0d, wanted %0d", $time, got, exp);
    end
  endtask

  task automatic chk_l(input logic [4:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: issue latency %0d, wanted %0d", $time, got, exp);
    end
  endtask

  function automatic cilm_instr_t mk(input cilm_op_t op, input logic [3:0] d);
    mk = IDLE;
    mk.op = op;
    mk.dst = d;
  endfunction

  // index below zero watches the multiplier instead of a register
  function automatic logic bz(input int r);
    return (r < 0) ? mac_busy : reg_busy[r];
  endfunction

  // issue one instruction, then count ready-low and busy cycles for two places
  task automatic go(input cilm_instr_t i, input int ra, rb, iss, la, lb);
    int nr, na, nb, hs;
    @(posedge sys_clk);
    instr <= i;
    instr_valid <= 1'b1;
    @(negedge sys_clk);
    repeat (40) if (instr_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    instr <= IDLE;
    nr = 0; na = 0; nb = 0; hs = 0;
    for (int k = 1; k <= 24; k++) begin
      @(negedge sys_clk);
      if (instr_ready !== 1'b1) nr++;
      if (bz(ra) === 1'b1) na++;
      if (bz(rb) === 1'b1) nb++;
      if (handler_start === 1'b1) hs = k;
    end
    chk_l(last_issue_lat, 5'(iss));
    chk_n(nr, iss - 1);
    chk_n(na, la - 1);
    chk_n(nb, lb - 1);
    chk_n(hs, (i.op == OP_EXCEPT) ? 6 : 0);
  endtask

  // producer then consumer held back to back; cycles between the two accepts
  task automatic gap(input cilm_instr_t p, c, input int exp);
    int n;
    @(posedge sys_clk);
    instr <= p;
    instr_valid <= 1'b1;
    @(negedge sys_clk);
    repeat (40) if (instr_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    instr <= c;
    n = 1;
    @(negedge sys_clk);
    while (instr_ready !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    instr <= IDLE;
    chk_n(n, exp);
    repeat (24) @(posedge sys_clk);
  endtask

  // single-result and no-result groups, each in both encodings
  task automatic t_table;
    cilm_instr_t i;
    cilm_op_t op [16] = '{OP_SAT, OP_SR_RD, OP_SWAP, OP_SYS_RD, OP_DBG_RD, OP_LZ_COUNT, OP_LOAD, OP_DATA,
      OP_SR_WR, OP_SYS_WR, OP_DBG_WR, OP_CP_LOAD, OP_CP_STORE, OP_PRELOAD, OP_STORE, OP_EXCEPT};
    int is [16] = '{1, 1, 5, 4, 8, 1, 1, 1, 2, 2, 8, 11, 8, 1, 1, 6};
    int r [16] = '{2, 2, 5, 4, 8, 1, 3, 1, 0, 0, 0, 0, 0, 0, 0, 0};
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 16; k++) begin
        i = mk(op[k], 4'h4);
        i.compressed = c[0];
        go(i, r[k] ? 4 : 9, 10, is[k], r[k] ? r[k] : 1, 1);
      end
    end
  endtask

  task automatic t_mac;
    cilm_instr_t i;
    logic [31:0] v [6] = '{32'h00007FFF, 32'h00008000, 32'hFFFF8000, 32'hFFFF7FFF, 32'h08000000, 32'hF7FFFFFF};
    int ex [6] = '{1, 2, 1, 2, 3, 3};
    for (int k = 0; k < 6; k++) begin
      i = mk(OP_ACC_MUL, 4'h0);
      i.mult_operand = v[k];
      go(i, -1, 9, 1, ex[k], 1);
    end
    go(mk(OP_ACC_MUL_HALF, 4'h0), -1, 9, 1, 1, 1);
    go(mk(OP_ACC_MUL_DUAL, 4'h0), -1, 9, 1, 2, 1);
    go(mk(OP_ACC_WR, 4'h0), -1, 9, 2, 2, 1);
    i = mk(OP_ACC_RD, 4'h1);
    i.dst2 = 4'h2;
    go(i, 1, 2, 1, 2, 3);
    gap(i, mk(OP_ACC_MUL, 4'h0), 2);
    // a slow multiply keeps the multiplier busy for three cycles
    i = mk(OP_ACC_MUL, 4'h0);
    i.mult_operand = v[4];
    gap(i, mk(OP_ACC_MUL_HALF, 4'h0), 3);
  endtask

  task automatic t_dep;
    cilm_instr_t p, c;
    p = mk(OP_ACC_RD, 4'h1);
    p.dst2 = 4'h2;
    c = mk(OP_SAT, 4'h6);
    c.src_a = 4'h1;
    c.src_a_en = 1'b1;
    gap(p, c, 2);
    c.special_use = 1'b1;
    gap(p, c, 3);
    c.special_use = 1'b0;
    c.src_a = 4'h3;
    gap(mk(OP_LOAD, 4'h3), c, 3);
    p = mk(OP_SR_WR, 4'h4);
    p.mode_change = 1'b1;
    go(p, 9, 10, 6, 1, 1);
  endtask

  task automatic t_mem;
    cilm_instr_t i;
    i = mk(OP_LOAD, 4'h4);
    i.base = 4'h5;
    i.wb_en = 1'b1;
    go(i, 4, 5, 1, 3, 1);
    i.op = OP_LOAD_DW;
    i.dst = 4'h2;
    go(i, 2, 3, 1, 3, 4);
    i.dst = 4'hC;
    go(i, 12, 5, 2, 3, 2);
    i.op = OP_STORE;
    go(i, 5, 9, 1, 1, 1);
    i.op = OP_STORE_DW;
    go(i, 5, 9, 2, 2, 1);
    i = mk(OP_LOAD_MULTI, 4'h0);
    i.base = 4'hF;
    i.wb_en = 1'b1;
    i.reg_list = 16'h3FFF;
    go(i, 13, 12, 16, 18, 17);
    go(i, 0, 15, 16, 16, 16);
    i.base = 4'h8;
    i.reg_list = 16'h0001;
    go(i, 0, 8, 3, 5, 3);
    i.op = OP_STORE_MULTI;
    i.reg_list = 16'h0007;
    go(i, 8, 0, 5, 5, 1);
    go(mk(OP_DBG_RD, 4'hF), 15, 9, 9, 9, 1);
  endtask

  task automatic t_branch;
    cilm_instr_t i;
    for (int c = 0; c < 2; c++) begin
      i = mk(OP_BRANCH, 4'h4);
      i.compressed = c[0];
      i.mispredict = 1'b1;
      go(i, 9, 10, 5 + c, 1, 1);
      i = mk(OP_PC_WRITE, 4'h4);
      i.compressed = c[0];
      i.taken = 1'b1;
      i.pc_issue = 5'h03;
      go(i, 9, 10, 3 + c, 1, 1);
    end
    i = mk(OP_LINK_HALF, 4'h4);
    i.compressed = 1'b1;
    go(i, 4, 9, 1, 1, 1);
    // the selector-one half is a plain branch, so a mispredict pays the compressed penalty
    i.hi_sel = 1'b1;
    i.mispredict = 1'b1;
    go(i, 9, 10, 6, 1, 1);
  endtask

  task automatic t_hold;
    int n;
    @(posedge sys_clk);
    hold <= 1'b1;
    instr <= mk(OP_LOAD, 4'h3);
    instr_valid <= 1'b1;
    n = 0;
    repeat (4) begin
      @(negedge sys_clk);
      if (instr_ready !== 1'b0) n++;
    end
    chk_n(n, 0);
    @(posedge sys_clk);
    hold <= 1'b0;
    instr_valid <= 1'b0;
    go(mk(OP_LOAD, 4'h3), 3, 9, 1, 3, 1);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_table();
    t_mac();
    t_dep();
    t_mem();
    t_branch();
    t_hold();
    wrap_up();
  end
endmodule // test_cilm_core

bind cilm_core cilm_core_asserts #(.NREG(NREG)) u_chk (.sys_clk, .rst, .instr_valid, .instr, .instr_ready,
  .hold, .handler_start, .reg_busy, .mac_busy, .last_issue_lat);
